// *** rtl/psmc_defs.svh ***
// Constants for the power save mode controller: register offsets, fields, resets.
// Assumes a 100 MHz REF_CLK and a 32-bit AXI4-Lite register bus.
// How it works
// - After any reset the controller sits in the default run state, all four clock groups running.
// - Out of reset the clock source is the system RC oscillator, FLL and PLLs off.
// - After reset no clock prescaler divides the system RC frequency.
// - On reset release the core boot address points at flash start, zero.
// - The analog supply monitor stays armed in every mode and resets the chip.
// - In any power save mode the core is held from executing instructions.
// - A wake-up returns to the run mode active at power save entry.
// - A reset during a power save mode always returns to the default run state.
// - I/O configuration is held frozen throughout every power save mode.
// - Sleep depth 0..3 stops CPU, then bus, peripheral/generic, then fast sources.
// - Light sleep gating overrides the bus and peripheral clock mask registers.
// - In light sleep only interrupts from still-clocked modules can wake.
// - Slow oscillators keep running in sleep only if enabled before entry.
// - Wait-for-interrupt enters light sleep when configured for that mode.
// - With sleep-on-exit set, leaving the lowest-priority ISR also enters sleep.
// - Any unmasked interrupt from a still-clocked group wakes light sleep and restarts clocks.
// - Wait and retention keep the core domain powered, preserving SRAM and registers.
// - Wait and retention stop all clocks but enabled 32 kHz sources.
// - Wait is the lowest mode where 32 kHz peripherals run autonomously.
// - Backup mode powers off the core domain and keeps the backup domain.
`ifndef PSMC_DEFS_SVH
`define PSMC_DEFS_SVH

`define PSMC_ADDR_CTRL 4'h0
`define PSMC_ADDR_STATUS 4'h4
`define PSMC_ADDR_MASK 4'h8
`define PSMC_ADDR_RUN 4'hc
`define PSMC_CTRL_DEPTH_LSB 0
`define PSMC_CTRL_DEEP_BIT 2
`define PSMC_CTRL_RET_BIT 3
`define PSMC_CTRL_BACKUP_SELECT_BIT 4
`define PSMC_CTRL_SOE_BIT 5
`define PSMC_CTRL_RESET 6'h00
`define PSMC_MASK_RESET 8'hff
`define PSMC_RUN_RESET 2'h0
`define PSMC_BOOT_ADDR 32'h0000_0000
`define PSMC_CLKEN_DEFAULT_RUN_STATE 4'hf
`define PSMC_GRP_CPU 0
`define PSMC_GRP_HSB 1
`define PSMC_GRP_PB 2
`define PSMC_GRP_FAST 3
`define PSMC_RESP_OKAY 2'h0
`define PSMC_RESP_SLVERR 2'h2

`endif

// *** rtl/psmc_pkg.sv ***
// Types shared by the power save mode controller.
// Assumes psmc_defs.svh supplies the numeric constants.
package psmc_pkg;
    typedef enum logic [2:0] {
        PSMC_RUN,
        PSMC_SLEEP,
        PSMC_WAIT,
        PSMC_RETAIN,
        PSMC_BACKUP
    } psmc_mode_t;

    // Clock gate enables, one bit per clock group
    typedef struct packed {
        logic fast_src;
        logic pb_generic_clock;
        logic hsb;
        logic cpu;
    } psmc_gates_t;

    // Software configuration bits
    typedef struct packed {
        logic sleep_on_isr_exit;
        logic backup_select;
        logic retention_select;
        logic deep_sleep_select;
        logic [1:0] sleep_depth_field;
    } psmc_cfg_t;
endpackage

// *** rtl/psmc_top.sv ***
// Power save mode controller: picks the mode on wait-for-interrupt, gates clocks,
// and brings the system back on wake-up or reset. Assumes the core pulses
// WFI_EXEC and ISR_EXIT for one cycle and all inputs are synchronous to REF_CLK.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "psmc_defs.svh"

module psmc_top (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic ANALOG_SUPPLY_POR,
    input wire logic WFI_EXEC,
    input wire logic ISR_EXIT,
    input wire logic [7:0] IRQ_PEND,
    input wire logic [7:0] IRQ_CLOCKED_GRP,
    input wire logic ASYNC_WAKE,
    input wire logic SLOW_XTAL_EN,
    input wire logic SLOW_RC_EN,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output psmc_pkg::psmc_gates_t CLK_GATES,
    output logic CPU_HALT,
    output logic CORE_PWR_EN,
    output logic IO_FREEZE,
    output logic SLOW_XTAL_RUN,
    output logic SLOW_RC_RUN,
    output logic CHIP_RST,
    output logic [31:0] BOOT_ADDR,
    output logic [1:0] RUN_MODE
);
    import psmc_pkg::*;

    psmc_mode_t mode_reg;
    psmc_mode_t mode_next;
    psmc_cfg_t cfg_reg;
    logic [7:0] mask_reg;
    logic [1:0] run_reg;
    logic [1:0] saved_run_reg;
    logic wake_sleep;
    logic enter;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic rst_any;
    psmc_gates_t gates_next;

    // Decode the two-bit depth into gate enables; 1 means clock runs
    function automatic psmc_gates_t depth_gates(input logic [1:0] depth);
        psmc_gates_t g;
        g = '0;
        g.hsb = (depth < 2'h1);
        g.pb_generic_clock = (depth < 2'h2);
        g.fast_src = (depth < 2'h3);
        return g;
    endfunction

    // Whole-chip reset: the analog supply monitor is never masked by a mode
    assign rst_any = SYS_RST | ANALOG_SUPPLY_POR;

    // Sleep wakes only on unmasked pending irqs from groups still clocked
    assign wake_sleep = |(IRQ_PEND & mask_reg & IRQ_CLOCKED_GRP);
    // Entry on WAIT_FOR_IRQ_INSTR, or on leaving the last ISR when sleep-on-exit is set
    assign enter = WFI_EXEC | (ISR_EXIT & cfg_reg.sleep_on_isr_exit);

    // Mode selection; synchronous clocks are stopped in deep modes, so only
    // the asynchronous wake line can bring them back
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            PSMC_RUN: begin
                if (enter) begin
                    if (!cfg_reg.deep_sleep_select) begin
                        mode_next = PSMC_SLEEP;
                    end else if (cfg_reg.backup_select) begin
                        mode_next = PSMC_BACKUP;
                    end else if (cfg_reg.retention_select) begin
                        mode_next = PSMC_RETAIN;
                    end else begin
                        mode_next = PSMC_WAIT;
                    end
                end
            end
            PSMC_SLEEP: begin
                if (wake_sleep) begin
                    mode_next = PSMC_RUN;
                end
            end
            PSMC_WAIT, PSMC_RETAIN, PSMC_BACKUP: begin
                if (ASYNC_WAKE) begin
                    mode_next = PSMC_RUN;
                end
            end
            default: begin
                mode_next = PSMC_RUN;
            end
        endcase
    end

    // Mode register; any reset lands in the default run state
    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            mode_reg <= PSMC_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Remember the run mode on entry so a wake-up restores it
    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            saved_run_reg <= `PSMC_RUN_RESET;
        end else if (mode_reg == PSMC_RUN && enter) begin
            saved_run_reg <= run_reg;
        end
    end

    // Clock gates per mode; sleep ignores the software mask registers
    always_comb begin
        gates_next = psmc_gates_t'(`PSMC_CLKEN_DEFAULT_RUN_STATE);
        case (mode_next)
            PSMC_SLEEP: gates_next = depth_gates(cfg_reg.sleep_depth_field);
            PSMC_WAIT, PSMC_RETAIN, PSMC_BACKUP: gates_next = '0;
            default: gates_next = psmc_gates_t'(`PSMC_CLKEN_DEFAULT_RUN_STATE);
        endcase
    end

    // Registered power-domain and clock outputs
    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            CLK_GATES <= psmc_gates_t'(`PSMC_CLKEN_DEFAULT_RUN_STATE);
            CPU_HALT <= 1'b0;
            CORE_PWR_EN <= 1'b1;
            IO_FREEZE <= 1'b0;
            SLOW_XTAL_RUN <= 1'b0;
            SLOW_RC_RUN <= 1'b0;
        end else begin
            CLK_GATES <= gates_next;
            CPU_HALT <= (mode_next != PSMC_RUN);
            CORE_PWR_EN <= (mode_next != PSMC_BACKUP);
            IO_FREEZE <= (mode_next != PSMC_RUN);
            // Slow sources keep going only if already enabled; wait keeps them
            // for autonomous 32 kHz peripherals
            SLOW_XTAL_RUN <= SLOW_XTAL_EN;
            SLOW_RC_RUN <= SLOW_RC_EN;
        end
    end

    // Reset cause out, boot address constant, and current run mode
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            CHIP_RST <= 1'b0;
            BOOT_ADDR <= `PSMC_BOOT_ADDR;
            RUN_MODE <= `PSMC_RUN_RESET;
        end else begin
            CHIP_RST <= ANALOG_SUPPLY_POR;
            BOOT_ADDR <= `PSMC_BOOT_ADDR;
            // Supply loss is a whole-chip reset, so it also drops to the default run state
            if (ANALOG_SUPPLY_POR) begin
                RUN_MODE <= `PSMC_RUN_RESET;
            end else begin
                RUN_MODE <= (mode_reg != PSMC_RUN && mode_next == PSMC_RUN) ? saved_run_reg
                    : run_reg;
            end
        end
    end

    // Write channel capture: address and data accepted in either order
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `PSMC_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (awaddr_reg[3:0] == `PSMC_ADDR_STATUS ||
                    awaddr_reg[31:4] != 28'h0) ? `PSMC_RESP_SLVERR : `PSMC_RESP_OKAY;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Ready flags: one outstanding write and one read at a time
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_hold_reg && !(S_AXI_AWVALID && S_AXI_AWREADY)
                && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_hold_reg && !(S_AXI_WVALID && S_AXI_WREADY)
                && !S_AXI_BVALID;
            S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
        end
    end

    // Register writes; byte lane 0 carries every field
    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            cfg_reg <= psmc_cfg_t'(`PSMC_CTRL_RESET);
            mask_reg <= `PSMC_MASK_RESET;
            run_reg <= `PSMC_RUN_RESET;
        end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID && wstrb_reg[0]
            && awaddr_reg[31:4] == 28'h0) begin
            case (awaddr_reg[3:0])
                `PSMC_ADDR_CTRL: cfg_reg <= psmc_cfg_t'(wdata_reg[5:0]);
                `PSMC_ADDR_MASK: mask_reg <= wdata_reg[7:0];
                `PSMC_ADDR_RUN: run_reg <= wdata_reg[1:0];
                default: mask_reg <= mask_reg;
            endcase
        end else if (mode_reg != PSMC_RUN && mode_next == PSMC_RUN) begin
            run_reg <= saved_run_reg;
        end
    end

    // Read channel; status shows the live mode and gates
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `PSMC_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `PSMC_RESP_OKAY;
            S_AXI_RDATA <= 32'h0000_0000;
            if (S_AXI_ARADDR[31:4] != 28'h0) begin
                S_AXI_RRESP <= `PSMC_RESP_SLVERR;
            end else begin
                case (S_AXI_ARADDR[3:0])
                    `PSMC_ADDR_CTRL: S_AXI_RDATA <= {26'h0, cfg_reg};
                    `PSMC_ADDR_STATUS: S_AXI_RDATA <= {25'h0, CLK_GATES, mode_reg};
                    `PSMC_ADDR_MASK: S_AXI_RDATA <= {24'h0, mask_reg};
                    `PSMC_ADDR_RUN: S_AXI_RDATA <= {30'h0, run_reg};
                    default: S_AXI_RRESP <= `PSMC_RESP_SLVERR;
                endcase
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Checks
    sequence enter_sleep_s;
        mode_reg == PSMC_RUN && enter && !cfg_reg.deep_sleep_select;
    endsequence

    reset_run_a: assert property (@(posedge REF_CLK) rst_any |=> mode_reg == PSMC_RUN
        && CLK_GATES == psmc_gates_t'(`PSMC_CLKEN_DEFAULT_RUN_STATE)) else $error("no run after reset");
    sleep_entry_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        enter_sleep_s |=> mode_reg == PSMC_SLEEP && CPU_HALT) else $error("sleep entry");
    cpu_halt_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        mode_reg != PSMC_RUN |-> CPU_HALT && !CLK_GATES.cpu) else $error("cpu runs");
    depth_gate_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        mode_reg == PSMC_SLEEP && $stable(cfg_reg) && $past(mode_reg) == PSMC_SLEEP |->
        CLK_GATES == depth_gates(cfg_reg.sleep_depth_field)) else $error("depth");
    deep_clocks_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        mode_reg inside {PSMC_WAIT, PSMC_RETAIN} |-> CLK_GATES == '0 && CORE_PWR_EN)
        else $error("deep gates");
    backup_pwr_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        mode_reg == PSMC_BACKUP |-> !CORE_PWR_EN) else $error("core powered");
    io_hold_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        mode_reg != PSMC_RUN |-> IO_FREEZE) else $error("io not frozen");
    wake_restore_a: assert property (@(posedge REF_CLK) disable iff (rst_any)
        mode_reg == PSMC_SLEEP && wake_sleep |=> mode_reg == PSMC_RUN
        && RUN_MODE == $past(saved_run_reg)) else $error("wake mode");
    boot_addr_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        BOOT_ADDR == `PSMC_BOOT_ADDR) else $error("boot address");
endmodule

// *** tb/psmc_core_model.sv ***
// Processor core stand-in: retires wait-for-interrupt or an ISR return as one-cycle pulses.
// Assumes the bench calls run_instr just after a rising edge of clk.
`timescale 1ns/1ps
module psmc_core_model (
    input wire logic clk,
    input wire logic cpu_halt,
    output logic wfi_exec,
    output logic isr_exit
);
    initial begin
        wfi_exec = 1'b0;
        isr_exit = 1'b0;
    end
    // A halted core executes nothing, so no pulse leaves it while halted
    task automatic run_instr(input logic is_wfi);
        if (cpu_halt === 1'b0) begin
            wfi_exec <= is_wfi;
            isr_exit <= !is_wfi;
        end
        @(posedge clk);
        wfi_exec <= 1'b0;
        isr_exit <= 1'b0;
    endtask
endmodule

// *** tb/psmc_top_tb.sv ***
// Self-checking bench for the power save mode controller, with a core stand-in.
// Assumes psmc_pkg, psmc_defs.svh, psmc_top and psmc_core_model compile first.
`timescale 1ns/1ps
`include "psmc_defs.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module psmc_top_tb;
    import psmc_pkg::*;
    localparam logic [31:0] A_CTRL = 32'(`PSMC_ADDR_CTRL);
    localparam logic [31:0] A_STAT = 32'(`PSMC_ADDR_STATUS);
    localparam logic [31:0] A_MASK = 32'(`PSMC_ADDR_MASK);
    localparam logic [31:0] A_RUN = 32'(`PSMC_ADDR_RUN);
    logic ref_clk = 1'b0, sys_rst = 1'b1, por = 1'b0, async_wake = 1'b0;
    logic xtal_en = 1'b0, rc_en = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
    logic ar_v = 1'b0, r_r = 1'b0, aw_r, w_r, b_v, ar_r, r_v, halt, pwr_en, freeze;
    logic xtal_run, rc_run, chip_rst, wait_for_irq_instr, isr;
    logic [7:0] irq_pend = 8'h00, irq_grp = 8'hff;
    logic [31:0] aw_addr = 32'h0, w_data = 32'h0, ar_addr = 32'h0, r_data, boot, rd_data;
    logic [1:0] b_resp, r_resp, run_mode, wr_resp, rd_resp;
    psmc_gates_t gates, eg;
    int mismatches = 0, total_checks = 0;
    psmc_top dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .ANALOG_SUPPLY_POR(por),
        .WFI_EXEC(wait_for_irq_instr), .ISR_EXIT(isr), .IRQ_PEND(irq_pend), .IRQ_CLOCKED_GRP(irq_grp),
        .ASYNC_WAKE(async_wake), .SLOW_XTAL_EN(xtal_en), .SLOW_RC_EN(rc_en),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
        .CLK_GATES(gates), .CPU_HALT(halt), .CORE_PWR_EN(pwr_en), .IO_FREEZE(freeze),
        .SLOW_XTAL_RUN(xtal_run), .SLOW_RC_RUN(rc_run), .CHIP_RST(chip_rst),
        .BOOT_ADDR(boot), .RUN_MODE(run_mode));
    psmc_core_model core (.clk(ref_clk), .cpu_halt(halt), .wfi_exec(wait_for_irq_instr), .isr_exit(isr));
    always #5 ref_clk = ~ref_clk;
    task automatic final_report();
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Leaves the bench 1 ns past an edge, so later drives never race the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Each channel is held until its own ready is seen at an edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        aw_addr <= a;
        w_data <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && aw_r === 1'b1) begin
                aw_done = 1'b1;
                aw_v <= 1'b0;
            end
            if (!w_done && w_r === 1'b1) begin
                w_done = 1'b1;
                w_v <= 1'b0;
            end
        end
        b_r <= 1'b1;
        do @(posedge ref_clk); while (b_v !== 1'b1);
        wr_resp = b_resp;
        b_r <= 1'b0;
        #1;
    endtask
    task automatic axi_rd(input logic [31:0] a);
        ar_addr <= a;
        ar_v <= 1'b1;
        do @(posedge ref_clk); while (ar_r !== 1'b1);
        ar_v <= 1'b0;
        r_r <= 1'b1;
        do @(posedge ref_clk); while (r_v !== 1'b1);
        rd_data = r_data;
        rd_resp = r_resp;
        r_r <= 1'b0;
        #1;
    endtask
    // Software programs the run mode and the selects before it executes the instruction
    task automatic enter(input logic [31:0] ctrl, input logic [31:0] run);
        axi_wr(A_RUN, run);
        axi_wr(A_CTRL, ctrl);
        core.run_instr(1'b1);
        cyc(3);
    endtask
    task automatic wake_by_irq(input logic [1:0] run);
        irq_pend <= 8'h01;
        cyc(3);
        `CHK("halt", 1'b0, halt)
        `CHK("gates", 4'hf, gates)
        `CHK("run_mode", run, run_mode)
        irq_pend <= 8'h00;
        cyc(1);
    endtask
    task automatic t_reset();
        `CHK("gates", 4'hf, gates)
        `CHK("halt", 1'b0, halt)
        `CHK("boot", `PSMC_BOOT_ADDR, boot)
        `CHK("run_mode", 2'h0, run_mode)
        axi_rd(A_STAT);
        `CHK("status", 32'h0000_0078, rd_data)
        axi_rd(A_MASK);
        `CHK("mask", 32'h0000_00ff, rd_data)
        axi_rd(32'h0000_0010);
        `CHK("unmapped", `PSMC_RESP_SLVERR, rd_resp)
        axi_wr(A_STAT, 32'h0000_0001);
        `CHK("status_wr", `PSMC_RESP_SLVERR, wr_resp)
        axi_wr(A_CTRL, 32'h0000_0003);
        axi_rd(A_CTRL);
        `CHK("ctrl", 32'h0000_0003, rd_data)
    endtask
    task automatic t_depths();
        for (int d = 0; d < 4; d++) begin
            eg = '{fast_src: d < 3, pb_generic_clock: d < 2, hsb: d < 1, cpu: 1'b0};
            enter(32'(d), 32'h1);
            `CHK("gates", eg, gates)
            `CHK("halt", 1'b1, halt)
            `CHK("freeze", 1'b1, freeze)
            wake_by_irq(2'h1);
        end
    endtask
    // A masked source and an unclocked source must both fail to wake
    task automatic t_block();
        axi_wr(A_MASK, 32'h0000_00fe);
        enter(32'h2, 32'h2);
        irq_grp <= 8'hfd;
        irq_pend <= 8'h03;
        cyc(4);
        `CHK("halt", 1'b1, halt)
        irq_grp <= 8'hff;
        cyc(3);
        `CHK("halt", 1'b0, halt)
        `CHK("run_mode", 2'h2, run_mode)
        irq_pend <= 8'h00;
        axi_wr(A_MASK, 32'h0000_00ff);
    endtask
    task automatic t_soe();
        axi_wr(A_CTRL, 32'h0000_0021);
        core.run_instr(1'b0);
        cyc(3);
        `CHK("gates", 4'hc, gates)
        wake_by_irq(2'h2);
    endtask
    task automatic t_deep();
        logic [31:0] cfg [3] = '{32'h04, 32'h0c, 32'h14};
        xtal_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            enter(cfg[i], 32'h3);
            irq_pend <= 8'hff;
            cyc(3);
            `CHK("halt", 1'b1, halt)
            `CHK("gates", 4'h0, gates)
            `CHK("xtal_run", 1'b1, xtal_run)
            `CHK("rc_run", 1'b0, rc_run)
            `CHK("pwr_en", i != 2, pwr_en)
            `CHK("freeze", 1'b1, freeze)
            async_wake <= 1'b1;
            cyc(3);
            async_wake <= 1'b0;
            irq_pend <= 8'h00;
            `CHK("halt", 1'b0, halt)
            `CHK("run_mode", 2'h3, run_mode)
        end
    endtask
    task automatic t_rst();
        enter(32'h04, 32'h3);
        sys_rst <= 1'b1;
        cyc(1);
        sys_rst <= 1'b0;
        cyc(2);
        `CHK("run_mode", 2'h0, run_mode)
        `CHK("gates", 4'hf, gates)
        enter(32'h14, 32'h2);
        por <= 1'b1;
        cyc(2);
        `CHK("chip_rst", 1'b1, chip_rst)
        por <= 1'b0;
        cyc(3);
        `CHK("pwr_en", 1'b1, pwr_en)
        `CHK("halt", 1'b0, halt)
        `CHK("run_mode", 2'h0, run_mode)
        `CHK("gates", 4'hf, gates)
    endtask
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        cyc(2);
        t_reset();
        t_depths();
        t_block();
        t_soe();
        t_deep();
        t_rst();
        final_report();
    end
endmodule
